// ==== ncor_pkg.sv ====
/*
  Package for the nonvolatile clock setup and option register block:
  register offsets, field positions, reset values and timing counts.
  Assumes an 8-bit register port with one-cycle strobes.
*/
package ncor_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CLOCK_SETUP   = 4'h0;
  localparam logic [3:0] OFS_OPTION_MIRROR = 4'h1;
  localparam logic [3:0] OFS_KEY_CTRL      = 4'h2; // bit 0 compare key write mode
  localparam logic [3:0] OFS_STATUS        = 4'h3; // block state
  localparam logic [3:0] OFS_KEY_DATA      = 4'h8; // eight key slots 8..F
  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int BIT_LOADED    = 7;
  localparam int BIT_PRESCALE  = 6;
  localparam int RATIO_W       = 6;
  localparam int BIT_UNLOCK_EN = 7;
  localparam int BIT_REDIR_OFF = 6;
  localparam int BIT_LAYOUT    = 5;
  localparam logic [1:0] LOCK_UNSECURED = 2'h2;
  localparam logic [7:0] OPTION_USED_MASK = 8'hE3; // bits 4:2 read zero
  localparam logic [7:0] CLOCK_SETUP_RESET = 8'h00;
  localparam int KEY_BYTES = 8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PRESCALE_DIV = 8;
  localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE_DIV - 1);
endpackage : ncor_pkg

// ==== ncor_div.sv ====
/*
  Programmable divider: emits a one-cycle pulse every (limit+1)
  enabled cycles. Assumes limit is stable while in use.
*/
`timescale 1ns/1ps
`default_nettype none
module ncor_div #(
  parameter int W = 6
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_run,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_limit,
  output logic              o_tick
);
  logic [W-1:0] cnt_q;

  // ---------------------------------------------------------------
  // counter, restarts while stopped so the first period is whole
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_run) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (i_en) begin
      o_tick <= (cnt_q == i_limit);
      cnt_q  <= (cnt_q == i_limit) ? '0 : W'(cnt_q + 1'b1);
    end else begin
      o_tick <= 1'b0;
    end
  end
endmodule : ncor_div
`default_nettype wire

// ==== ncor_keycmp.sv ====
/*
  Backdoor key comparator: walks eight ordered key writes and flags
  a full match. Assumes stored key is stable after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ncor_keycmp (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic        i_wr,
  input  wire logic [2:0]  i_slot,
  input  wire logic [7:0]  i_data,
  input  wire logic [63:0] i_key,
  input  wire logic        i_finish,
  output logic             o_match
);
  import ncor_pkg::*;
  logic [3:0] idx_q;
  logic       ok_q;

  // ---------------------------------------------------------------
  // order and value tracking; an out-of-order write spoils the try
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_start) begin
      idx_q <= 4'h0;
      ok_q  <= 1'b1;
    end else if (i_wr) begin
      if (idx_q[3] || (i_slot != idx_q[2:0]) ||
          (i_data != i_key[8*i_slot +: 8]))
        ok_q <= 1'b0;
      if (!idx_q[3])
        idx_q <= 4'(idx_q + 1'b1);
    end
  end

  // match pulse when the mode closes after all eight good bytes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n)
      o_match <= 1'b0;
    else
      o_match <= i_finish && ok_q && (idx_q == 4'(KEY_BYTES));
  end
endmodule : ncor_keycmp
`default_nettype wire

// ==== ncor_regs.sv ====
/*
  Clock setup and option mirror registers of the nonvolatile memory
  controller, with timing pulse generation, security state and the
  backdoor key path. Assumes the option byte and stored key are held
  stable by the array, and that a bus master sources one strobe at once.
*/
`timescale 1ns/1ps
`default_nettype none
module ncor_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_bdm_access,
  output logic [7:0]       o_rdata,
  // nonvolatile sources
  input  wire logic [7:0]  i_nv_option_byte,
  input  wire logic [63:0] i_stored_unlock_key,
  input  wire logic        i_blank_check_ok,
  // memory access gate
  input  wire logic        i_mem_req,
  input  wire logic        i_mem_we,
  input  wire logic        i_mem_src_unsecured,
  input  wire logic [7:0]  i_mem_rdata,
  output logic             o_mem_we,
  output logic [7:0]       o_mem_rdata,
  // controller status
  input  wire logic        i_op_req,
  output logic             o_op_grant,
  output logic             o_op_refused,
  output logic             o_timing_pulse,
  output logic             o_secure,
  output logic             o_vector_redirect_on,
  output logic             o_eeprom_sector_layout,
  output logic             o_backdoor_unlock_enable
);
  import ncor_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              clock_setting_loaded_q;
  logic              prescale_by_eight_q;
  logic [RATIO_W-1:0] ratio_q;
  logic [7:0]        nv_option_mirror_q;
  logic [1:0]        lock_state_code_q;
  logic              compare_key_write_mode_q;
  logic [2:0]        pre_cnt_q;
  logic              pre_tick;
  logic              div_in_en;
  logic              nv_timing_clock_tick;
  logic              key_match;
  logic              key_wr;
  logic              key_finish;
  logic              fw_wr;
  logic              unsecure_evt;

  // firmware writes only; debug-sourced writes never reach key logic
  assign fw_wr = i_wr && !i_bdm_access;

  // ---------------------------------------------------------------
  // clock setup register
  // ---------------------------------------------------------------
  // the flag doubles as the lock, so no later write can retune timing
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clock_setting_loaded_q <= CLOCK_SETUP_RESET[BIT_LOADED];
      prescale_by_eight_q    <= CLOCK_SETUP_RESET[BIT_PRESCALE];
      ratio_q                <= CLOCK_SETUP_RESET[RATIO_W-1:0];
    end else if (i_wr && i_addr == OFS_CLOCK_SETUP && !clock_setting_loaded_q) begin
      clock_setting_loaded_q <= 1'b1;
      prescale_by_eight_q    <= i_wdata[BIT_PRESCALE];
      ratio_q                <= i_wdata[RATIO_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // timing clock: optional divide by eight, then ratio plus one
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !clock_setting_loaded_q) begin
      pre_cnt_q <= 3'h0;
    end else begin
      pre_cnt_q <= 3'(pre_cnt_q + 1'b1);
    end
  end

  assign pre_tick  = (pre_cnt_q == PRESCALE_LAST);
  assign div_in_en = prescale_by_eight_q ? pre_tick : 1'b1;

  // divider stays idle until setup is loaded, avoiding a bogus rate
  ncor_div #(
    .W (RATIO_W)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (clock_setting_loaded_q),
    .i_en      (div_in_en),
    .i_limit   (ratio_q),
    .o_tick    (nv_timing_clock_tick)
  );

  // one timing clock cycle per pulse; sequencer counts whole pulses
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n)
      o_timing_pulse <= 1'b0;
    else
      o_timing_pulse <= nv_timing_clock_tick;
  end

  // ---------------------------------------------------------------
  // erase and program permission
  // ---------------------------------------------------------------
  // rate range is software's duty; hardware only checks the flag
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_op_grant   <= 1'b0;
      o_op_refused <= 1'b0;
    end else begin
      o_op_grant   <= i_op_req && clock_setting_loaded_q;
      o_op_refused <= i_op_req && !clock_setting_loaded_q;
    end
  end

  // ---------------------------------------------------------------
  // option mirror and lock state
  // ---------------------------------------------------------------
  // capture is continuous during reset; bus writes have no path here
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n)
      nv_option_mirror_q <= i_nv_option_byte & OPTION_USED_MASK;
  end

  assign unsecure_evt = (key_match && nv_option_mirror_q[BIT_UNLOCK_EN])
                        || i_blank_check_ok;

  // lock code follows the byte at reset and is forced open by events
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n)
      lock_state_code_q <= i_nv_option_byte[1:0];
    else if (unsecure_evt)
      lock_state_code_q <= LOCK_UNSECURED;
  end

  // ---------------------------------------------------------------
  // backdoor key path
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n)
      compare_key_write_mode_q <= 1'b0;
    else if (fw_wr && i_addr == OFS_KEY_CTRL)
      compare_key_write_mode_q <= i_wdata[0];
  end

  assign key_wr     = fw_wr && compare_key_write_mode_q && i_addr[3];
  assign key_finish = fw_wr && i_addr == OFS_KEY_CTRL &&
                      compare_key_write_mode_q && !i_wdata[0];

  ncor_keycmp u_key (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (fw_wr && i_addr == OFS_KEY_CTRL && i_wdata[0]),
    .i_wr      (key_wr),
    .i_slot    (i_addr[2:0]),
    .i_data    (i_wdata),
    .i_key     (i_stored_unlock_key),
    .i_finish  (key_finish),
    .o_match   (key_match)
  );

  // ---------------------------------------------------------------
  // secure memory gate
  // ---------------------------------------------------------------
  // blocked reads return zero rather than stale data, so nothing leaks
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_mem_we    <= 1'b0;
      o_mem_rdata <= 8'h00;
    end else begin
      o_mem_we    <= i_mem_req && i_mem_we &&
                     !(o_secure && i_mem_src_unsecured);
      o_mem_rdata <= (o_secure && i_mem_src_unsecured) ? 8'h00 : i_mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // decoded option outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_secure                 <= 1'b1;
      o_vector_redirect_on     <= 1'b0;
      o_eeprom_sector_layout   <= 1'b0;
      o_backdoor_unlock_enable <= 1'b0;
    end else begin
      o_secure                 <= (lock_state_code_q != LOCK_UNSECURED) && !unsecure_evt;
      o_vector_redirect_on     <= !nv_option_mirror_q[BIT_REDIR_OFF];
      o_eeprom_sector_layout   <= nv_option_mirror_q[BIT_LAYOUT];
      o_backdoor_unlock_enable <= nv_option_mirror_q[BIT_UNLOCK_EN];
    end
  end

  // ---------------------------------------------------------------
  // read port, data valid the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        OFS_CLOCK_SETUP:   o_rdata <= {clock_setting_loaded_q, prescale_by_eight_q, ratio_q};
        OFS_OPTION_MIRROR: o_rdata <= {nv_option_mirror_q[7:2], lock_state_code_q};
        OFS_KEY_CTRL:      o_rdata <= {7'h00, compare_key_write_mode_q};
        OFS_STATUS:        o_rdata <= {6'h00, o_secure, clock_setting_loaded_q};
        default:           o_rdata <= 8'h00; // key slots read zero
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_loaded_once;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == OFS_CLOCK_SETUP) |=> clock_setting_loaded_q;
  endproperty
  a_loaded_once: assert property (p_loaded_once) else $error("loaded flag not set");

  property p_write_once;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      clock_setting_loaded_q |=> $stable({prescale_by_eight_q, ratio_q});
  endproperty
  a_write_once: assert property (p_write_once) else $error("setup changed twice");

  property p_refuse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_op_req && !clock_setting_loaded_q) |=> (o_op_refused && !o_op_grant);
  endproperty
  a_refuse: assert property (p_refuse) else $error("op not refused");

  property p_no_tick_unloaded;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !clock_setting_loaded_q |-> ##2 !o_timing_pulse;
  endproperty
  a_no_tick_unloaded: assert property (p_no_tick_unloaded) else $error("pulse before load");

  sequence s_pulse;
    o_timing_pulse;
  endsequence
  property p_pulse_single;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s_pulse and prescale_by_eight_q) |=> !o_timing_pulse [*7];
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("prescaled pulse too soon");

  property p_key_gate;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (key_match && !nv_option_mirror_q[BIT_UNLOCK_EN] && !i_blank_check_ok)
        |=> $stable(lock_state_code_q);
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("unlock while disabled");

  property p_force_open;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_blank_check_ok |=> (lock_state_code_q == LOCK_UNSECURED) ##1 !o_secure;
  endproperty
  a_force_open: assert property (p_force_open) else $error("lock not forced");

  property p_block_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_secure && i_mem_src_unsecured) |=> (o_mem_rdata == 8'h00) && !o_mem_we;
  endproperty
  a_block_read: assert property (p_block_read) else $error("blocked access leaked");

  property p_opt_ro;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rst_n |=> $stable(nv_option_mirror_q);
  endproperty
  a_opt_ro: assert property (p_opt_ro) else $error("option mirror changed");

  property p_grant;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_op_req && clock_setting_loaded_q) |=> (o_op_grant && !o_op_refused);
  endproperty
  a_grant: assert property (p_grant) else $error("op not granted");

  property p_pulse_width;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_timing_pulse && (ratio_q != '0)) |=> !o_timing_pulse;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too long");

  property p_bdm_key;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_bdm_access) |=> $stable(compare_key_write_mode_q);
  endproperty
  a_bdm_key: assert property (p_bdm_key) else $error("debug write reached key mode");

  // unlock is a two step chain: match pulse, then lock code and flag open together
  sequence s_key_hit;
    key_match && nv_option_mirror_q[BIT_UNLOCK_EN];
  endsequence
  sequence s_opened;
    (lock_state_code_q == LOCK_UNSECURED) && !o_secure;
  endsequence
  property p_unlock;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_key_hit |=> s_opened;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key match did not unlock");

  // decoded outputs track the mirror, which never moves outside reset
  property p_decode;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> (o_vector_redirect_on != nv_option_mirror_q[BIT_REDIR_OFF]) &&
               (o_eeprom_sector_layout == nv_option_mirror_q[BIT_LAYOUT]);
  endproperty
  a_decode: assert property (p_decode) else $error("option decode wrong");

  property p_pass_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!o_secure || !i_mem_src_unsecured) |=> (o_mem_rdata == $past(i_mem_rdata));
  endproperty
  a_pass_read: assert property (p_pass_read) else $error("allowed read altered");
endmodule : ncor_regs
`default_nettype wire

// ==== ncor_regs_test.sv ====
/*
  Self-checking testbench for the clock setup and option mirror block.
  Assumes the register port answers a read in the following cycle and
  that the security state settles within four cycles of a key sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module ncor_regs_test;
  import ncor_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
  logic        i_sys_clk, i_rst_n, i_wr, i_rd, i_bdm_access, i_blank_check_ok;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, i_nv_option_byte, i_mem_rdata, o_rdata, o_mem_rdata;
  logic        i_mem_req, i_mem_we, i_mem_src_unsecured, i_op_req;
  logic        o_mem_we, o_op_grant, o_op_refused, o_timing_pulse, o_secure;
  logic        o_vector_redirect_on, o_eeprom_sector_layout, o_backdoor_unlock_enable;
  int          n_mismatch, n_checks;
  logic [7:0]  rv;

  ncor_regs uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_bdm_access(i_bdm_access),
    .o_rdata(o_rdata), .i_nv_option_byte(i_nv_option_byte),
    .i_stored_unlock_key(KEY), .i_blank_check_ok(i_blank_check_ok),
    .i_mem_req(i_mem_req), .i_mem_we(i_mem_we), .i_mem_src_unsecured(i_mem_src_unsecured),
    .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we), .o_mem_rdata(o_mem_rdata),
    .i_op_req(i_op_req), .o_op_grant(o_op_grant), .o_op_refused(o_op_refused),
    .o_timing_pulse(o_timing_pulse), .o_secure(o_secure),
    .o_vector_redirect_on(o_vector_redirect_on),
    .o_eeprom_sector_layout(o_eeprom_sector_layout),
    .o_backdoor_unlock_enable(o_backdoor_unlock_enable));

  // ---------------------------------------------------------------
  // clock and shared tasks
  // ---------------------------------------------------------------
  // free running 100 MHz bus clock
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // reset is held sixteen cycles so the option byte is copied in
  task automatic do_reset(input logic [7:0] opt);
    @(posedge i_sys_clk);
    i_rst_n          <= 1'b0;
    i_nv_option_byte <= opt;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic background_debug_mode);
    @(posedge i_sys_clk);
    i_addr       <= a;
    i_wdata      <= d;
    i_bdm_access <= background_debug_mode;
    i_wr         <= 1'b1;
    @(posedge i_sys_clk);
    i_wr         <= 1'b0;
    i_bdm_access <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic op(input logic grant);
    @(posedge i_sys_clk);
    i_op_req <= 1'b1;
    @(posedge i_sys_clk);
    i_op_req <= 1'b0;
    #1 chk({6'h00, o_op_grant, o_op_refused}, {6'h00, grant, ~grant}, "op answer");
  endtask : op

  task automatic mem(input logic we, input logic uns, input logic pass);
    @(posedge i_sys_clk);
    {i_mem_req, i_mem_we, i_mem_src_unsecured, i_mem_rdata} <= {1'b1, we, uns, 8'h5A};
    @(posedge i_sys_clk);
    i_mem_req <= 1'b0;
    #1 chk({7'h00, o_mem_we}, {7'h00, we & pass}, "mem write gate");
    if (!we) chk(o_mem_rdata, pass ? 8'h5A : 8'h00, "mem read gate");
  endtask : mem

  // distance in cycles between two timing pulses; a stuck pulse fails too
  task automatic measure(input int exp);
    int n;
    n = 0;
    while (o_timing_pulse !== 1'b1 && n < 1200) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    @(posedge i_sys_clk);
    #1 n = 1;
    while (o_timing_pulse !== 1'b1 && n < 1200) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    // whole-count compare, in-range periods run past eight bits
    chk({7'h00, n == exp}, 8'h01, "pulse period");
  endtask : measure

  // compare key mode on, eight ordered slots, mode off
  task automatic key_seq(input logic [63:0] k, input logic background_debug_mode, input logic exp_sec);
    wr(OFS_KEY_CTRL, 8'h01, background_debug_mode);
    for (int i = 0; i < KEY_BYTES; i++) wr(OFS_KEY_DATA + 4'(i), k[8*i +: 8], background_debug_mode);
    wr(OFS_KEY_CTRL, 8'h00, background_debug_mode);
    repeat (4) @(posedge i_sys_clk);
    #1 chk({7'h00, o_secure}, {7'h00, exp_sec}, "secure after key");
  endtask : key_seq

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_clock_setup;
    rd(OFS_CLOCK_SETUP, rv); chk(rv, CLOCK_SETUP_RESET, "setup reset");
    op(1'b0);
    wr(OFS_CLOCK_SETUP, 8'h05, 1'b0);
    rd(OFS_CLOCK_SETUP, rv); chk(rv, 8'h85, "setup first write");
    wr(OFS_CLOCK_SETUP, 8'h7F, 1'b0);
    rd(OFS_CLOCK_SETUP, rv); chk(rv, 8'h85, "setup second write");
    op(1'b1);
    measure(6);
  endtask : t_clock_setup

  task automatic t_option;
    rd(OFS_OPTION_MIRROR, rv); chk(rv, 8'hA3, "mirror load");
    wr(OFS_OPTION_MIRROR, 8'h00, 1'b0);
    i_nv_option_byte <= 8'h00;
    rd(OFS_OPTION_MIRROR, rv); chk(rv, 8'hA3, "mirror held");
    rd(OFS_KEY_DATA, rv); chk(rv, 8'h00, "key slot read");
    rd(4'h4, rv); chk(rv, 8'h00, "unmapped read");
    mem(1'b1, 1'b1, 1'b0);
    mem(1'b0, 1'b1, 1'b0);
    mem(1'b0, 1'b0, 1'b1);
  endtask : t_option

  task automatic t_backdoor;
    key_seq(KEY, 1'b1, 1'b1);
    key_seq(KEY ^ 64'h0100, 1'b0, 1'b1);
    key_seq(KEY, 1'b0, 1'b0);
    rd(OFS_OPTION_MIRROR, rv); chk(rv, 8'hA2, "lock code after key");
    mem(1'b0, 1'b1, 1'b1);
  endtask : t_backdoor

  task automatic t_no_unlock;
    key_seq(KEY, 1'b0, 1'b1);
    wr(OFS_CLOCK_SETUP, 8'h7F, 1'b0); // about 195 kHz from the 100 MHz bus
    measure(512);
    @(posedge i_sys_clk);
    i_blank_check_ok <= 1'b1;
    @(posedge i_sys_clk);
    i_blank_check_ok <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 chk({7'h00, o_secure}, 8'h00, "secure after blank check");
  endtask : t_no_unlock

  // every lock code with the decoded option bits varied alongside
  task automatic t_codes;
    logic [7:0] o;
    for (int c = 0; c < 4; c++) begin
      o = {c[1], c[0], ~c[0], 3'b000, 2'(c)};
      do_reset(o);
      chk({7'h00, o_secure}, {7'h00, 2'(c) != LOCK_UNSECURED}, "lock decode");
      chk({5'h00, o_backdoor_unlock_enable, o_vector_redirect_on, o_eeprom_sector_layout},
          {5'h00, o[7], ~o[6], o[5]}, "decoded options");
    end
  endtask : t_codes

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {i_rst_n, i_wr, i_rd, i_bdm_access, i_blank_check_ok, i_op_req} = '0;
    {i_mem_req, i_mem_we, i_mem_src_unsecured} = '0;
    {i_addr, i_wdata, i_mem_rdata} = '0;
    i_nv_option_byte = 8'hBF;
    n_mismatch = 0;
    n_checks   = 0;
    do_reset(8'hBF);
    t_clock_setup();
    t_option();
    t_backdoor();
    do_reset(8'h3F);
    t_no_unlock();
    t_codes();
    end_sim();
  end

  // the whole run is about 1300 cycles; far beyond that is a hang
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : ncor_regs_test
`default_nettype wire
